// ===== mfc_conv.sv
// modbus query handler that converts to fieldbus commands
`default_nettype none
module mfc_conv #(
	parameter int TIMEOUT_CYC = mfc_pkg::FB_TIMEOUT_CYC // answer timeout
) (
	input  wire logic        CLK,          // clock, 125 mhz
	input  wire logic        RST,          // synchronous reset, high
	input  wire logic        ASCII_MODE,   // 1 lrc framing, 0 crc framing
	input  wire logic        RX_VALID,     // query byte valid
	output logic             RX_READY,     // query byte accepted
	input  wire logic [7:0]  RX_DATA,      // query byte
	input  wire logic        RX_LAST,      // last byte of frame
	output logic             TX_VALID,     // answer byte valid
	input  wire logic        TX_READY,     // answer byte taken
	output logic      [7:0]  TX_DATA,      // answer byte
	output logic             TX_LAST,      // last answer byte
	output logic             FB_CMD_VALID, // fieldbus command valid
	input  wire logic        FB_CMD_READY, // fieldbus command taken
	output logic      [7:0]  FB_UNIT,      // remote unit address
	output logic      [7:0]  FB_CMD,       // fieldbus command id
	output logic      [15:0] FB_ARG,       // command argument
	output logic             FB_BCAST,     // broadcast, no answer follows
	input  wire logic        FB_ANS_VALID, // fieldbus answer valid
	input  wire logic [15:0] FB_ANS_DATA,  // answer value
	input  wire logic        FB_ANS_FAIL,  // unit reported failure
	input  wire logic        FB_ANS_NAK,   // unit refused the function
	output logic             FRAME_DROP    // pulse, frame discarded
);
	mfc_pkg::mfc_state_e state;      // sequencer state
	logic [7:0]  q [0:5];            // query body bytes
	logic [3:0]  rx_cnt;             // received byte count, saturating
	logic [15:0] rx_crc;             // running crc of the query
	logic [7:0]  rx_lrc;             // running byte sum of the query
	logic [15:0] next_rx_crc;        // crc including current byte
	logic [7:0]  next_rx_lrc;        // sum including current byte
	logic [3:0]  next_rx_cnt;        // count including current byte
	logic        frame_ok;           // checksum and length good
	logic [7:0]  exc;                // exception code of this query
	logic [7:0]  chk_exc;            // exception from decode
	logic [7:0]  chk_cmd;            // command from decode
	logic [15:0] chk_arg;            // argument from decode
	logic [15:0] ans;                // captured answer value
	logic [31:0] tmo;                // timeout counter
	logic [2:0]  bptr;               // build pointer
	logic [2:0]  tptr;               // transmit pointer
	logic [2:0]  rsp_len;            // answer body length
	logic [7:0]  rsp_byte;           // answer byte being built
	logic [15:0] tx_crc;             // running crc of the answer
	logic [7:0]  tx_lrc;             // running byte sum of the answer
	logic        ck_idx;             // which checksum byte is sent
	logic [7:0]  mem_rd;             // answer byte from the store
	logic        bcast;              // query was broadcast
	logic [15:0] offs;               // zero-based data offset
	logic [15:0] dval;               // count or data field
	logic [15:0] coil_bits;          // packed status coils
	logic        tx_hs;              // answer byte handshake

	// one crc step, used for query and answer alike
	function automatic logic [15:0] crc_step(input logic [15:0] c,
		input logic [7:0] b);
		logic [15:0] r;
		r = c ^ {8'h00, b};
		for (int i = 0; i < 8; i++) begin
			r = r[0] ? ((r >> 1) ^ mfc_pkg::CRC_POLY) : (r >> 1);
		end
		return r;
	endfunction : crc_step

	// status coils of the remote thermocouple, lsb first from offs
	function automatic logic [15:0] pack_coils(input logic [15:0] st,
		input logic [15:0] qty, input logic [15:0] ans_w);
		logic [15:0] r;
		logic [15:0] c;
		r = 16'h0000;
		for (int i = 0; i < 16; i++) begin
			c = st + 16'(i);
			if (16'(i) < qty && c >= mfc_pkg::TC_STAT_LO &&
				c <= mfc_pkg::TC_STAT_HI) begin
				r[i] = ans_w[3'(c - mfc_pkg::TC_STAT_LO)];
			end
		end
		return r;
	endfunction : pack_coils

	assign offs  = {q[2], q[3]};
	assign dval  = {q[4], q[5]};
	assign bcast = (q[0] == mfc_pkg::ADDR_BCAST);

	// running checksum of the byte arriving now
	always_comb begin
		next_rx_crc = crc_step(rx_crc, RX_DATA);
		next_rx_lrc = rx_lrc + RX_DATA;
		next_rx_cnt = (rx_cnt == 4'hF) ? rx_cnt : rx_cnt + 4'h1;
		frame_ok = ASCII_MODE ?
			(next_rx_lrc == 8'h00 && next_rx_cnt == mfc_pkg::LEN_ASCII) :
			(next_rx_crc == 16'h0000 && next_rx_cnt == mfc_pkg::LEN_RTU);
	end

	// decode the query against the conversion table
	always_comb begin
		chk_exc = mfc_pkg::EXC_NONE;
		chk_cmd = 8'h00;
		chk_arg = 16'h0000;
		unique case (q[1])
			mfc_pkg::FN_RD_STATUS: begin
				chk_cmd = mfc_pkg::CMD_RD_STAT;
				if (dval == 16'h0000 || dval > mfc_pkg::QTY_MAX_BIT) begin
					chk_exc = mfc_pkg::EXC_VALUE;
				end else if (offs > mfc_pkg::TC_STAT_HI ||
					offs + dval - 16'h0001 < mfc_pkg::TC_STAT_LO) begin
					chk_exc = mfc_pkg::EXC_ADDR;
				end
			end
			mfc_pkg::FN_RD_INREG: begin
				if (offs < mfc_pkg::TC_IREG_LO || offs > mfc_pkg::TC_IREG_HI)
				begin
					chk_exc = mfc_pkg::EXC_ADDR;
				end else if (dval != mfc_pkg::QTY_ONE) begin
					chk_exc = mfc_pkg::EXC_VALUE;
				end
				unique case (offs[2:0])
					3'd7:    chk_cmd = mfc_pkg::CMD_RD_SETPT;
					3'd0:    chk_cmd = mfc_pkg::CMD_RD_HIGH;
					3'd1:    chk_cmd = mfc_pkg::CMD_RD_LOW;
					3'd2:    chk_cmd = mfc_pkg::CMD_RD_TEMP;
					default: chk_cmd = mfc_pkg::CMD_RD_COLD;
				endcase
			end
			mfc_pkg::FN_WR_COIL: begin
				chk_cmd = mfc_pkg::CMD_RELAY;
				chk_arg = {15'h0000, dval == mfc_pkg::COIL_ON};
				if (offs != mfc_pkg::TC_COIL_RLY) begin
					chk_exc = mfc_pkg::EXC_ADDR;
				end else if (dval != mfc_pkg::COIL_ON &&
					dval != mfc_pkg::COIL_OFF) begin
					chk_exc = mfc_pkg::EXC_VALUE;
				end
			end
			mfc_pkg::FN_WR_HREG: begin
				chk_cmd = mfc_pkg::CMD_WR_SETPT;
				chk_arg = dval;
				if (offs != mfc_pkg::TC_HREG_SP) begin
					chk_exc = mfc_pkg::EXC_ADDR;
				end else if ($signed(dval) < mfc_pkg::TC_SP_MIN ||
					$signed(dval) > mfc_pkg::TC_SP_MAX) begin
					chk_exc = mfc_pkg::EXC_VALUE;
				end
			end
			default: chk_exc = mfc_pkg::EXC_FUNC;
		endcase
	end

	// sequencer
	always_ff @(posedge CLK) begin
		if (RST) begin
			state <= mfc_pkg::ST_IDLE;
		end else begin
			unique case (state)
				mfc_pkg::ST_IDLE: begin
					// bad checksum, length or address: drop silently
					if (RX_VALID && RX_LAST && frame_ok &&
						q[0] <= mfc_pkg::ADDR_MAX) begin
						state <= mfc_pkg::ST_CHECK;
					end
				end
				mfc_pkg::ST_CHECK: begin
					// broadcast never gets an answer, so errors die here
					if (bcast && (chk_exc != mfc_pkg::EXC_NONE ||
						q[1] == mfc_pkg::FN_RD_STATUS ||
						q[1] == mfc_pkg::FN_RD_INREG)) begin
						state <= mfc_pkg::ST_IDLE;
					end else if (chk_exc != mfc_pkg::EXC_NONE) begin
						state <= mfc_pkg::ST_BUILD;
					end else begin
						state <= mfc_pkg::ST_ISSUE;
					end
				end
				mfc_pkg::ST_ISSUE: begin
					if (FB_CMD_READY) begin
						state <= bcast ? mfc_pkg::ST_IDLE :
							mfc_pkg::ST_WAIT;
					end
				end
				mfc_pkg::ST_WAIT: begin
					if (FB_ANS_VALID || tmo == 32'(TIMEOUT_CYC - 1)) begin
						state <= mfc_pkg::ST_BUILD;
					end
				end
				mfc_pkg::ST_BUILD: begin
					if (bptr == rsp_len - 3'd1) begin
						state <= mfc_pkg::ST_FETCH;
					end
				end
				mfc_pkg::ST_FETCH: state <= mfc_pkg::ST_SEND;
				mfc_pkg::ST_SEND: begin
					if (TX_READY) begin
						state <= (tptr == rsp_len - 3'd1) ?
							mfc_pkg::ST_CKSUM : mfc_pkg::ST_FETCH;
					end
				end
				mfc_pkg::ST_CKSUM: begin
					if (TX_READY && TX_LAST) begin
						state <= mfc_pkg::ST_IDLE;
					end
				end
			endcase
		end
	end

	// query capture and checksum over received bytes
	always_ff @(posedge CLK) begin
		if (RST) begin
			rx_cnt <= 4'h0;
			rx_crc <= mfc_pkg::CRC_INIT;
			rx_lrc <= 8'h00;
			for (int i = 0; i < 6; i++) begin
				q[i] <= 8'h00;
			end
		end else if (state == mfc_pkg::ST_IDLE && RX_VALID) begin
			if (rx_cnt < 4'h6) begin
				q[rx_cnt[2:0]] <= RX_DATA;
			end
			// restart counting at every frame end
			rx_cnt <= RX_LAST ? 4'h0 : next_rx_cnt;
			rx_crc <= RX_LAST ? mfc_pkg::CRC_INIT : next_rx_crc;
			rx_lrc <= RX_LAST ? 8'h00 : next_rx_lrc;
		end
	end

	// drop pulse for frames that fail checksum, length or address
	always_ff @(posedge CLK) begin
		if (RST) begin
			FRAME_DROP <= 1'b0;
		end else begin
			FRAME_DROP <= state == mfc_pkg::ST_IDLE && RX_VALID &&
				RX_LAST && !(frame_ok && q[0] <= mfc_pkg::ADDR_MAX);
		end
	end

	// fieldbus command registers, held until taken
	always_ff @(posedge CLK) begin
		if (RST) begin
			FB_UNIT  <= 8'h00;
			FB_CMD   <= 8'h00;
			FB_ARG   <= 16'h0000;
			FB_BCAST <= 1'b0;
		end else if (state == mfc_pkg::ST_CHECK) begin
			FB_UNIT  <= q[0];
			FB_CMD   <= chk_cmd;
			FB_ARG   <= chk_arg;
			FB_BCAST <= bcast;
		end
	end

	// exception code and answer value
	always_ff @(posedge CLK) begin
		if (RST) begin
			exc <= mfc_pkg::EXC_NONE;
			ans <= 16'h0000;
		end else if (state == mfc_pkg::ST_CHECK) begin
			exc <= chk_exc;
		end else if (state == mfc_pkg::ST_WAIT) begin
			if (FB_ANS_VALID) begin
				ans <= FB_ANS_DATA;
				if (FB_ANS_NAK) begin
					exc <= mfc_pkg::EXC_NAK;
				end else if (FB_ANS_FAIL) begin
					exc <= mfc_pkg::EXC_FAIL;
				end
			end else if (tmo == 32'(TIMEOUT_CYC - 1)) begin
				exc <= mfc_pkg::EXC_FAIL;
			end
		end
	end

	// answer timeout; a silent unit counts as a device failure
	always_ff @(posedge CLK) begin
		if (RST || state != mfc_pkg::ST_WAIT) begin
			tmo <= 32'h0000_0000;
		end else begin
			tmo <= tmo + 32'h0000_0001;
		end
	end

	assign coil_bits = pack_coils(offs, dval, ans);

	// answer length by kind
	always_comb begin
		if (exc != mfc_pkg::EXC_NONE) begin
			rsp_len = 3'd3;
		end else if (q[1] == mfc_pkg::FN_RD_INREG) begin
			rsp_len = 3'd5;
		end else if (q[1] == mfc_pkg::FN_RD_STATUS) begin
			rsp_len = (dval > 16'h0008) ? 3'd5 : 3'd4;
		end else begin
			rsp_len = 3'd6;
		end
	end

	// answer byte at the build pointer
	always_comb begin
		rsp_byte = q[bptr];
		unique case (bptr)
			3'd0: rsp_byte = q[0];
			3'd1: rsp_byte = (exc != mfc_pkg::EXC_NONE) ?
				(q[1] + mfc_pkg::FN_EXC_FLAG) : q[1];
			3'd2: begin
				if (exc != mfc_pkg::EXC_NONE) begin
					rsp_byte = exc;
				end else if (q[1] == mfc_pkg::FN_RD_INREG) begin
					rsp_byte = mfc_pkg::BYTE_COUNT1;
				end else if (q[1] == mfc_pkg::FN_RD_STATUS) begin
					rsp_byte = {5'h00, rsp_len - 3'd3};
				end
			end
			3'd3: begin
				if (q[1] == mfc_pkg::FN_RD_INREG) begin
					rsp_byte = ans[15:8];
				end else if (q[1] == mfc_pkg::FN_RD_STATUS) begin
					rsp_byte = coil_bits[7:0];
				end
			end
			3'd4: begin
				if (q[1] == mfc_pkg::FN_RD_INREG) begin
					rsp_byte = ans[7:0];
				end else if (q[1] == mfc_pkg::FN_RD_STATUS) begin
					rsp_byte = coil_bits[15:8];
				end
			end
			default: rsp_byte = q[bptr];
		endcase
	end

	// build and transmit pointers
	always_ff @(posedge CLK) begin
		if (RST || state == mfc_pkg::ST_CHECK) begin
			bptr   <= 3'd0;
			tptr   <= 3'd0;
			ck_idx <= 1'b0;
		end else if (state == mfc_pkg::ST_BUILD) begin
			bptr <= bptr + 3'd1;
		end else if (state == mfc_pkg::ST_SEND && TX_READY) begin
			tptr <= tptr + 3'd1;
		end else if (state == mfc_pkg::ST_CKSUM && TX_READY) begin
			ck_idx <= 1'b1;
		end
	end

	// checksum of the answer as it leaves
	always_ff @(posedge CLK) begin
		if (RST || state == mfc_pkg::ST_CHECK) begin
			tx_crc <= mfc_pkg::CRC_INIT;
			tx_lrc <= 8'h00;
		end else if (state == mfc_pkg::ST_SEND && TX_READY) begin
			tx_crc <= crc_step(tx_crc, mem_rd);
			tx_lrc <= tx_lrc + mem_rd;
		end
	end

	// answer store; a register file would waste muxes on six bytes
	mfc_mem #(
		.W     (8),
		.DEPTH (8)
	) u_mem (
		.CLK     (CLK),
		.WR_EN   (state == mfc_pkg::ST_BUILD),
		.WR_ADDR (bptr),
		.WR_DATA (rsp_byte),
		.RD_ADDR (tptr),
		.RD_DATA (mem_rd)
	);

	assign tx_hs = TX_VALID && TX_READY;

	// port handshakes and the outgoing byte
	always_comb begin
		RX_READY     = (state == mfc_pkg::ST_IDLE);
		FB_CMD_VALID = (state == mfc_pkg::ST_ISSUE);
		TX_VALID     = (state == mfc_pkg::ST_SEND) ||
			(state == mfc_pkg::ST_CKSUM);
		TX_LAST      = (state == mfc_pkg::ST_CKSUM) && (ASCII_MODE || ck_idx);
		if (state == mfc_pkg::ST_CKSUM) begin
			// lrc is the negated sum, crc goes low byte first
			TX_DATA = ASCII_MODE ? (8'h00 - tx_lrc) :
				(ck_idx ? tx_crc[15:8] : tx_crc[7:0]);
		end else if (state == mfc_pkg::ST_SEND) begin
			TX_DATA = mem_rd;
		end else begin
			TX_DATA = 8'h00;
		end
	end
endmodule : mfc_conv
`default_nettype wire

// ===== mfc_pkg.sv
// shared constants and types of the modbus function converter
`default_nettype none
package mfc_pkg;
	// function codes handled on the main port
	localparam logic [7:0] FN_RD_STATUS = 8'h02; // read input status
	localparam logic [7:0] FN_RD_INREG  = 8'h04; // read input register
	localparam logic [7:0] FN_WR_COIL   = 8'h05; // force single coil
	localparam logic [7:0] FN_WR_HREG   = 8'h06; // preset single register
	localparam logic [7:0] FN_EXC_FLAG  = 8'h80; // added on exception
	// exception codes
	localparam logic [7:0] EXC_NONE     = 8'h00; // no exception
	localparam logic [7:0] EXC_FUNC     = 8'h01; // illegal function
	localparam logic [7:0] EXC_ADDR     = 8'h02; // illegal data address
	localparam logic [7:0] EXC_VALUE    = 8'h03; // illegal data value
	localparam logic [7:0] EXC_FAIL     = 8'h04; // slave device failure
	localparam logic [7:0] EXC_NAK      = 8'h07; // negative acknowledge
	// slave addresses
	localparam logic [7:0] ADDR_BCAST   = 8'h00; // broadcast
	localparam logic [7:0] ADDR_MAX     = 8'hF7; // highest unit address
	// field values
	localparam logic [15:0] COIL_ON     = 16'hFF00; // coil on constant
	localparam logic [15:0] COIL_OFF    = 16'h0000; // coil off constant
	localparam logic [7:0]  BYTE_COUNT1 = 8'h01; // byte count of reg read
	localparam logic [15:0] QTY_ONE     = 16'h0001; // one register
	localparam logic [15:0] QTY_MAX_BIT = 16'h0010; // status bits per answer
	// zero-based offsets of the thermocouple unit map
	localparam logic [15:0] TC_STAT_LO  = 16'h00C7; // status coil 0200
	localparam logic [15:0] TC_STAT_HI  = 16'h00CB; // status coil 0204
	localparam logic [15:0] TC_COIL_RLY = 16'h00C7; // relay coil 0200
	localparam logic [15:0] TC_IREG_LO  = 16'h00C7; // input register 0200
	localparam logic [15:0] TC_IREG_HI  = 16'h00CB; // input register 0204
	localparam logic [15:0] TC_HREG_SP  = 16'h00C8; // holding register 0201
	// setpoint range in degrees c
	localparam logic signed [15:0] TC_SP_MIN = -16'sd210; // lowest setpoint
	localparam logic signed [15:0] TC_SP_MAX = 16'sd1820; // highest setpoint
	// fieldbus command identifiers
	localparam logic [7:0] CMD_RD_SETPT = 8'h53; // read setpoint
	localparam logic [7:0] CMD_RD_HIGH  = 8'h55; // read high threshold
	localparam logic [7:0] CMD_RD_LOW   = 8'h44; // read low threshold
	localparam logic [7:0] CMD_RD_TEMP  = 8'h54; // read sensor temperature
	localparam logic [7:0] CMD_RD_COLD  = 8'h4A; // read cold junction
	localparam logic [7:0] CMD_RD_STAT  = 8'h3F; // read status word
	localparam logic [7:0] CMD_RELAY    = 8'h52; // relay on or off
	localparam logic [7:0] CMD_WR_SETPT = 8'h57; // write setpoint
	// checksum
	localparam logic [15:0] CRC_INIT    = 16'hFFFF; // crc start value
	localparam logic [15:0] CRC_POLY    = 16'hA001; // reflected polynomial
	// frame lengths with checksum
	localparam logic [3:0] LEN_RTU      = 4'h8; // body plus two crc bytes
	localparam logic [3:0] LEN_ASCII    = 4'h7; // body plus one lrc byte
	// fieldbus answer timeout
	localparam int FB_TIMEOUT_US = 10000; // microseconds
	localparam int CLK_MHZ       = 125; // clock rate
	localparam int FB_TIMEOUT_CYC = FB_TIMEOUT_US * CLK_MHZ; // cycles
	// sequencer states, gray along the path
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_CHECK = 3'b001,
		ST_ISSUE = 3'b011,
		ST_WAIT  = 3'b010,
		ST_BUILD = 3'b110,
		ST_FETCH = 3'b111,
		ST_SEND  = 3'b101,
		ST_CKSUM = 3'b100
	} mfc_state_e;
endpackage : mfc_pkg
`default_nettype wire

// ===== mfc_mem.sv
// small response byte store with registered read data
`default_nettype none
module mfc_mem #(
	parameter int W     = 8, // word width
	parameter int DEPTH = 8  // number of words
) (
	input  wire logic                     CLK,     // clock
	input  wire logic                     WR_EN,   // write strobe
	input  wire logic [$clog2(DEPTH)-1:0] WR_ADDR, // write address
	input  wire logic [W-1:0]             WR_DATA, // write data
	input  wire logic [$clog2(DEPTH)-1:0] RD_ADDR, // read address
	output logic      [W-1:0]             RD_DATA  // read data, registered
);
	logic [W-1:0] store [0:DEPTH-1]; // storage words

	// write port
	always_ff @(posedge CLK) begin
		if (WR_EN) begin
			store[WR_ADDR] <= WR_DATA;
		end
	end

	// read port, one cycle latency
	always_ff @(posedge CLK) begin
		RD_DATA <= store[RD_ADDR];
	end
endmodule : mfc_mem
`default_nettype wire

// ===== mfc_conv_asserts.sv
// port assertions of the modbus function converter
`default_nettype none
module mfc_conv_asserts (
	input wire logic        CLK,          // clock
	input wire logic        RST,          // sync reset, high
	input wire logic        RX_READY,     // query byte accepted
	input wire logic        TX_VALID,     // answer byte valid
	input wire logic        TX_READY,     // answer byte taken
	input wire logic [7:0]  TX_DATA,      // answer byte
	input wire logic        FB_CMD_VALID, // command offered
	input wire logic        FB_CMD_READY, // command taken
	input wire logic [7:0]  FB_UNIT,      // remote unit
	input wire logic [7:0]  FB_CMD,       // command id
	input wire logic [15:0] FB_ARG,       // argument
	input wire logic        FB_BCAST,     // broadcast
	input wire logic        FRAME_DROP    // frame discarded
);
	default clocking @(posedge CLK); endclocking
	default disable iff (RST);
	// a dropped frame must leave the port idle and mute
	drop_idle_a: assert property (
		FRAME_DROP |-> RX_READY && !TX_VALID)
		else $error("dropped frame not idle");
	// accepting queries means nothing is in flight
	idle_quiet_a: assert property (
		RX_READY |-> !TX_VALID && !FB_CMD_VALID)
		else $error("busy while ready");
	// broadcast flag follows unit zero, units stop at f7
	bcast_unit_a: assert property (
		FB_CMD_VALID |-> FB_BCAST == (FB_UNIT == 8'h00) && FB_UNIT <= 8'hf7)
		else $error("bad unit or broadcast flag");
	// a broadcast command gets no answer in the 8 cycles after it is taken
	bcast_mute_a: assert property (
		FB_CMD_VALID && FB_CMD_READY && FB_BCAST |=> !TX_VALID [*8])
		else $error("answer to broadcast");
	// reads are never broadcast
	bcast_write_a: assert property (
		FB_CMD_VALID && FB_BCAST |-> FB_CMD inside {8'h52, 8'h57})
		else $error("broadcast read forwarded");
	// command fields hold until taken
	cmd_hold_a: assert property (
		FB_CMD_VALID && !FB_CMD_READY |=> FB_CMD_VALID
		&& $stable(FB_CMD) && $stable(FB_ARG))
		else $error("command changed before taken");
	// answer bytes hold through a stall
	tx_hold_a: assert property (
		TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_DATA))
		else $error("answer byte changed in stall");
	// relay argument is only on or off
	relay_arg_a: assert property (
		FB_CMD_VALID && FB_CMD == 8'h52 |-> FB_ARG <= 16'h0001)
		else $error("relay argument invalid");
	// setpoint stays within -210 .. 1820
	setpt_rng_a: assert property (
		FB_CMD_VALID && FB_CMD == 8'h57 |->
		$signed(FB_ARG) >= -210 && $signed(FB_ARG) <= 1820)
		else $error("setpoint out of range");
endmodule : mfc_conv_asserts
bind mfc_conv mfc_conv_asserts chk (.CLK(CLK), .RST(RST), .RX_READY(RX_READY),
	.TX_VALID(TX_VALID), .TX_READY(TX_READY), .TX_DATA(TX_DATA),
	.FB_CMD_VALID(FB_CMD_VALID), .FB_CMD_READY(FB_CMD_READY),
	.FB_UNIT(FB_UNIT), .FB_CMD(FB_CMD), .FB_ARG(FB_ARG),
	.FB_BCAST(FB_BCAST), .FRAME_DROP(FRAME_DROP));
`default_nettype wire

// ===== mfc_master.sv
// modbus master model: sends query frames and gathers answers
`default_nettype none
module mfc_master (
	input  wire logic       CLK,      // clock
	output var logic        RX_VALID, // query byte valid
	output var logic  [7:0] RX_DATA,  // query byte
	output var logic        RX_LAST,  // frame end
	input  wire logic       RX_READY, // byte taken
	input  wire logic       TX_VALID, // answer byte valid
	input  wire logic [7:0] TX_DATA,  // answer byte
	input  wire logic       TX_LAST,  // answer end
	output var logic        TX_READY  // answer byte taken
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] resp[$]; // answer bytes, exceptions included
	int         last_at; // byte count when the end mark came
	logic       slow;    // stall every other cycle
	initial begin
		RX_VALID = 1'b0;
		RX_DATA = 8'h00;
		RX_LAST = 1'b0;
		TX_READY = 1'b0;
		slow = 1'b0;
		last_at = 0;
	end
	// send one frame; each byte holds until the edge that takes it
	task automatic send(input logic [7:0] f[$]);
		foreach (f[i]) begin
			RX_VALID <= 1'b1;
			RX_DATA <= f[i];
			RX_LAST <= (i == f.size() - 1);
			do @(negedge CLK); while (RX_READY !== 1'b1);
			@(posedge CLK);
		end
		RX_VALID <= 1'b0;
		RX_LAST <= 1'b0;
		RX_DATA <= ~RX_DATA; // released line must not look valid
	endtask : send
	// sample at the settled half cycle; exceptions are kept for the bench
	always @(negedge CLK) begin
		if (TX_VALID === 1'b1 && TX_READY) begin
			resp.push_back(TX_DATA);
			if (TX_LAST === 1'b1) last_at = resp.size();
		end
	end
	// a slow master is ready on every other cycle
	always @(posedge CLK) TX_READY <= slow ? ~TX_READY : 1'b1;
endmodule : mfc_master
`default_nettype wire

// ===== mfc_conv_tb.sv
// self-checking bench of the modbus function converter
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin errors++; \
	$display("wrong value at %0t: %h vs %h", $time, a, b); end end
module mfc_conv_tb;
	timeunit 1ns;
	timeprecision 1ps;
	typedef logic [7:0] mfc_q_t[$];
	logic        clk, rst, asc;          // clock, reset, lrc framing
	logic        rx_v, rx_r, rx_l;       // query handshake
	logic [7:0]  rx_d, tx_d, fb_u, fb_c; // bytes
	logic        tx_v, tx_r, tx_l;       // answer handshake
	logic        fb_cv, fb_cr, fb_b;     // command handshake
	logic [15:0] fb_a, fb_ad, got_a;     // argument, answer data
	logic        fb_av, fb_f, fb_n;      // fieldbus answer
	logic        drop, take, got_b;      // drop pulse, taken command
	logic [7:0]  got_c;                  // last command id
	int          errors, n_tests, n_cmd, n_drop, mode, bad, dly;
	mfc_conv #(.TIMEOUT_CYC(50)) dut (.CLK(clk), .RST(rst), .ASCII_MODE(asc),
		.RX_VALID(rx_v), .RX_READY(rx_r), .RX_DATA(rx_d), .RX_LAST(rx_l),
		.TX_VALID(tx_v), .TX_READY(tx_r), .TX_DATA(tx_d), .TX_LAST(tx_l),
		.FB_CMD_VALID(fb_cv), .FB_CMD_READY(fb_cr), .FB_UNIT(fb_u),
		.FB_CMD(fb_c), .FB_ARG(fb_a), .FB_BCAST(fb_b), .FB_ANS_VALID(fb_av),
		.FB_ANS_DATA(fb_ad), .FB_ANS_FAIL(fb_f), .FB_ANS_NAK(fb_n),
		.FRAME_DROP(drop));
	mfc_master m (.CLK(clk), .RX_VALID(rx_v), .RX_DATA(rx_d), .RX_LAST(rx_l),
		.RX_READY(rx_r), .TX_VALID(tx_v), .TX_DATA(tx_d), .TX_LAST(tx_l),
		.TX_READY(tx_r));
	always #4 clk = ~clk;
	// fieldbus unit: note taken commands at the settled half cycle
	always @(negedge clk) begin
		take = fb_cv && fb_cr;
		if (take) begin
			n_cmd++;
			got_c = fb_c;
			got_a = fb_a;
			got_b = fb_b;
		end
		if (drop === 1'b1) n_drop++;
	end
	// answer three cycles later; mode 1 fail, 2 refuse, 3 stay mute
	always @(posedge clk) begin
		fb_cr <= ~fb_cr; // ready on every other cycle
		fb_av <= 1'b0;
		if (take && !got_b && mode != 3) dly <= 3;
		else if (dly != 0) dly <= dly - 1;
		if (dly == 1) begin
			fb_av <= 1'b1;
			fb_f <= (mode == 1);
			fb_n <= (mode == 2);
		end
	end
	// append lrc or crc (low byte first)
	function automatic void ck(ref mfc_q_t f);
		logic [15:0] c;
		logic [7:0]  s;
		c = 16'hffff;
		s = 8'h00;
		foreach (f[i]) begin
			s += f[i];
			c ^= {8'h00, f[i]};
			repeat (8) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
		end
		if (asc) f.push_back(-s);
		else f = {f, c[7:0], c[15:8]};
	endfunction : ck
	// one query; exc zero means normal answer, c the expected command
	task automatic txn(input logic [7:0] u, fn, input logic [15:0] off,
		val, input logic [7:0] exc, c);
		mfc_q_t b, e, f;
		int     c0, d0;
		b = '{u, fn, off[15:8], off[7:0], val[15:8], val[7:0]};
		if (u == 8'h00 || bad != 0) e = '{};
		else if (exc != 8'h00) e = '{u, fn | 8'h80, exc};
		else if (fn == 8'h04) e = '{u, fn, 8'h01, fb_ad[15:8], fb_ad[7:0]};
		// five status coils from the first land in answer bits 0..4
		else if (fn == 8'h02) e = '{u, fn, 8'h01, {3'h0, fb_ad[4:0]}};
		else e = b;
		f = b;
		ck(f);
		if (bad == 1) f[2] ^= 8'h01; // spoil the checksum
		c0 = n_cmd;
		d0 = n_drop;
		m.resp.delete();
		m.last_at = 0;
		m.send(f);
		repeat (3) @(negedge clk);
		while (rx_r !== 1'b1) @(negedge clk);
		repeat (4) @(posedge clk);
		if (e.size() > 0) ck(e);
		`CHK(m.resp.size(), e.size())
		`CHK(m.last_at, e.size())
		foreach (e[i]) `CHK(m.resp[i], e[i])
		`CHK(n_cmd - c0, int'(c != 8'h00))
		`CHK(n_drop - d0, int'(bad != 0))
		if (c != 8'h00) `CHK(got_c, c)
		if (c == 8'h52) `CHK(got_a, {15'h0000, val == 16'hff00})
		if (c == 8'h57) `CHK(got_a, val)
	endtask : txn
	// every mapped input register and the status coils, unit 01
	task automatic t_read;
		logic [7:0] cmd[5] = '{8'h53, 8'h55, 8'h44, 8'h54, 8'h4a};
		foreach (cmd[i])
			txn(8'h01, 8'h04, 16'h00c7 + 16'(i), 16'h0001, 8'h00, cmd[i]);
		txn(8'h01, 8'h02, 16'h00c7, 16'h0005, 8'h00, 8'h3f);
	endtask : t_read
	// refused reads and functions
	task automatic t_errs;
		txn(8'hf7, 8'h04, 16'h00c7, 16'h0002, 8'h03, 8'h00);
		txn(8'h01, 8'h04, 16'h00c6, 16'h0001, 8'h02, 8'h00);
		txn(8'h00, 8'h04, 16'h00c7, 16'h0001, 8'h00, 8'h00);
		txn(8'h01, 8'h03, 16'h00c7, 16'h0001, 8'h01, 8'h00);
	endtask : t_errs
	// relay coil forcing, echo and broadcast
	task automatic t_coil;
		txn(8'h02, 8'h05, 16'h00c7, 16'hff00, 8'h00, 8'h52);
		txn(8'h02, 8'h05, 16'h00c7, 16'h0000, 8'h00, 8'h52);
		txn(8'h02, 8'h05, 16'h00c7, 16'h1234, 8'h03, 8'h00);
		txn(8'h02, 8'h05, 16'h00c8, 16'hff00, 8'h02, 8'h00);
		txn(8'h00, 8'h05, 16'h00c7, 16'hff00, 8'h00, 8'h52);
	endtask : t_coil
	// setpoint preset, range ends and broadcast
	task automatic t_preset;
		txn(8'hf7, 8'h06, 16'h00c8, 16'h03e8, 8'h00, 8'h57);
		txn(8'hf7, 8'h06, 16'h00c8, 16'hff2e, 8'h00, 8'h57);
		txn(8'hf7, 8'h06, 16'h00c8, 16'h071d, 8'h03, 8'h00);
		txn(8'h00, 8'h06, 16'h00c8, 16'h071c, 8'h00, 8'h57);
		txn(8'h01, 8'h06, 16'h00c9, 16'h0001, 8'h02, 8'h00);
	endtask : t_preset
	// unit failure, refusal, silence, and a slow master
	task automatic t_fault;
		mode = 2;
		txn(8'h01, 8'h04, 16'h00cb, 16'h0001, 8'h07, 8'h4a);
		mode = 1;
		txn(8'h01, 8'h04, 16'h00ca, 16'h0001, 8'h04, 8'h54);
		mode = 3;
		txn(8'h01, 8'h04, 16'h00c9, 16'h0001, 8'h04, 8'h44);
		mode = 0;
		m.slow = 1'b1;
		txn(8'h01, 8'h04, 16'h00c8, 16'h0001, 8'h00, 8'h55);
		m.slow = 1'b0;
	endtask : t_fault
	// bad checksum, bad address, lrc framing
	task automatic t_frame;
		bad = 1;
		txn(8'h01, 8'h04, 16'h00c7, 16'h0001, 8'h00, 8'h00);
		bad = 2;
		txn(8'hf8, 8'h04, 16'h00c7, 16'h0001, 8'h00, 8'h00);
		bad = 0;
		// framing input moves on the edge; let it settle before the frame
		asc <= 1'b1;
		@(posedge clk);
		txn(8'h02, 8'h05, 16'h00c7, 16'hff00, 8'h00, 8'h52);
		asc <= 1'b0;
	endtask : t_frame
	task automatic report_and_stop;
		$display("errors %0d of %0d checks", errors, n_tests);
		if (errors == 0 && n_tests > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : report_and_stop
	// hang guard, well beyond the expected run
	initial begin
		repeat (20000) @(posedge clk);
		errors++;
		report_and_stop();
	end
	initial begin
		{clk, rst, asc, fb_cr, fb_av, fb_f, fb_n} = 7'h01 << 5;
		{errors, n_tests, n_cmd, n_drop, mode, bad, dly} = '0;
		fb_ad = 16'hff2e; // -210 read back
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_read();
		t_errs();
		t_coil();
		t_preset();
		t_fault();
		t_frame();
		report_and_stop();
	end
endmodule : mfc_conv_tb
`default_nettype wire
